/* File: src/nalu_pkg.sv */
// Shared types and constants of the nibble ALU with skip logic.
// Assumes one 40 MHz clock and a sequencer on the same clock that decodes instructions.
// Function
// - Load immediate; runs of loads keep only first.
// - Table read: high nibble to aux, low to accumulator.
// - Table address is pointer low bits, then accumulator.
// - Table read holds one return stack level.
// - Bank set reaches pages 64-127, clear 0-63.
// - Reset or wake selects pages 0 to 63.
// - Add memory to accumulator, carry unchanged.
// - Add memory and carry; carry takes carry out.
// - Add immediate, carry kept, skip without overflow.
// - Accumulator ANDed with addressed memory nibble.
// - Accumulator ORed with addressed memory nibble.
// - Set carry flag to one.
// - Clear carry flag to zero.
// - Skip next instruction when carry is zero.
// - Accumulator replaced by its one's complement.
// - Rotate accumulator right through carry flag.
// - Set selected bit of addressed memory nibble.
// - Clear selected bit of addressed memory nibble.
// - Skip next when selected memory bit is zero.
// - Skip next when accumulator equals memory nibble.
// - Skip next when accumulator equals immediate.
package nalu_pkg;

    localparam int NALU_NIB_W = 4;
    localparam int NALU_PAGE_W = 6;
    localparam int NALU_PTR_W = 3;
    localparam int NALU_ROM_AW = 14;
    localparam int NALU_ROM_DW = 8;
    localparam int NALU_HI_LSB = 4;

    localparam logic [3:0] NALU_NIB_RST = 4'h0;
    localparam logic NALU_CARRY_RST = 1'b0;
    localparam logic NALU_BANK_LOW = 1'b0;

    typedef enum logic [4:0] {
        NALU_OP_NOP,
        NALU_OP_LOAD_IMM,
        NALU_OP_TABLE_READ,
        NALU_OP_BANK_SET,
        NALU_OP_BANK_CLR,
        NALU_OP_ADD_MEM,
        NALU_OP_ADDC_MEM,
        NALU_OP_ADD_IMM,
        NALU_OP_AND_MEM,
        NALU_OP_OR_MEM,
        NALU_OP_SET_CARRY,
        NALU_OP_CLR_CARRY,
        NALU_OP_TEST_CARRY,
        NALU_OP_COMPL,
        NALU_OP_ROT_RIGHT,
        NALU_OP_BIT_SET,
        NALU_OP_BIT_CLR,
        NALU_OP_BIT_TEST,
        NALU_OP_CMP_MEM,
        NALU_OP_CMP_IMM
    } nalu_op_e;

    typedef enum logic {
        NALU_TAB_IDLE,
        NALU_TAB_WAIT
    } nalu_tab_e;

    typedef struct packed {
        logic valid;
        nalu_op_e op;
        logic [NALU_NIB_W-1:0] imm;
        logic [NALU_PAGE_W-1:0] page;
    } nalu_instr_s;

    typedef struct packed {
        logic [NALU_NIB_W-1:0] acc;
        logic acc_we;
        logic carry;
        logic carry_we;
        logic [NALU_NIB_W-1:0] mem;
        logic mem_we;
        logic skip;
    } nalu_res_s;

    typedef struct packed {
        logic [NALU_NIB_W-1:0] acc;
        logic [NALU_NIB_W-1:0] aux;
        logic carry;
        logic bank;
        logic load_run;
        nalu_tab_e tab;
        logic skip_req;
        logic mem_we;
        logic [NALU_NIB_W-1:0] mem_wdata;
        logic rom_req;
        logic [NALU_ROM_AW-1:0] rom_addr;
        logic push;
        logic pop;
    } nalu_state_s;

    localparam nalu_state_s NALU_STATE_RST = '{
        acc: NALU_NIB_RST,
        aux: NALU_NIB_RST,
        carry: NALU_CARRY_RST,
        bank: NALU_BANK_LOW,
        load_run: 1'b0,
        tab: NALU_TAB_IDLE,
        skip_req: 1'b0,
        mem_we: 1'b0,
        mem_wdata: NALU_NIB_RST,
        rom_req: 1'b0,
        rom_addr: 14'h0000,
        push: 1'b0,
        pop: 1'b0
    };

endpackage

/* File: src/nalu_alu.sv */
// Combinational arithmetic, logic, bit and compare unit of the nibble ALU.
// Assumes the caller applies the write enables only for executed instructions.
`timescale 1ns/1ps
module nalu_alu
    import nalu_pkg::*;
(
    // Operation
    input wire nalu_op_e op_i,
    input wire logic [3:0] imm_i,
    // Operands
    input wire logic [3:0] acc_i,
    input wire logic carry_i,
    input wire logic [3:0] mem_i,
    // Result
    output nalu_res_s res_o
);

    logic [4:0] sum;
    logic [3:0] addend;
    logic cin;
    logic [3:0] bit_mask;

    always_comb
    begin
        addend = (op_i == NALU_OP_ADD_IMM) ? imm_i : mem_i;
        cin = (op_i == NALU_OP_ADDC_MEM) ? carry_i : 1'b0;
        sum = {1'b0, acc_i} + {1'b0, addend} + {4'h0, cin};
        bit_mask = 4'h1 << imm_i[1:0];
        res_o = '0;
        res_o.acc = acc_i;
        res_o.carry = carry_i;
        res_o.mem = mem_i;
        case (op_i)
            NALU_OP_ADD_MEM:
            begin
                res_o.acc = sum[3:0];
                res_o.acc_we = 1'b1;
            end
            NALU_OP_ADDC_MEM:
            begin
                res_o.acc = sum[3:0];
                res_o.carry = sum[4];
                res_o.acc_we = 1'b1;
                res_o.carry_we = 1'b1;
            end
            NALU_OP_ADD_IMM:
            begin
                res_o.acc = sum[3:0];
                res_o.acc_we = 1'b1;
                res_o.skip = ~sum[4];
            end
            NALU_OP_AND_MEM:
            begin
                res_o.acc = acc_i & mem_i;
                res_o.acc_we = 1'b1;
            end
            NALU_OP_OR_MEM:
            begin
                res_o.acc = acc_i | mem_i;
                res_o.acc_we = 1'b1;
            end
            NALU_OP_SET_CARRY:
            begin
                res_o.carry = 1'b1;
                res_o.carry_we = 1'b1;
            end
            NALU_OP_CLR_CARRY:
            begin
                res_o.carry = 1'b0;
                res_o.carry_we = 1'b1;
            end
            NALU_OP_TEST_CARRY:
            begin
                res_o.skip = ~carry_i;
            end
            NALU_OP_COMPL:
            begin
                res_o.acc = ~acc_i;
                res_o.acc_we = 1'b1;
            end
            NALU_OP_ROT_RIGHT:
            begin
                res_o.acc = {carry_i, acc_i[3:1]};
                res_o.carry = acc_i[0];
                res_o.acc_we = 1'b1;
                res_o.carry_we = 1'b1;
            end
            NALU_OP_BIT_SET:
            begin
                res_o.mem = mem_i | bit_mask;
                res_o.mem_we = 1'b1;
            end
            NALU_OP_BIT_CLR:
            begin
                res_o.mem = mem_i & ~bit_mask;
                res_o.mem_we = 1'b1;
            end
            NALU_OP_BIT_TEST:
            begin
                res_o.skip = ~mem_i[imm_i[1:0]];
            end
            NALU_OP_CMP_MEM:
            begin
                res_o.skip = (acc_i == mem_i);
            end
            NALU_OP_CMP_IMM:
            begin
                res_o.skip = (acc_i == imm_i);
            end
            default:
            begin
                res_o.acc_we = 1'b0;
            end
        endcase
    end

endmodule

/* File: src/nalu_core.sv */
// Execution datapath of the nibble ALU: accumulator, auxiliary register, carry,
// table-read bank and the skip requests handed back to the program sequencer.
// Assumes the sequencer, data memory and program memory all run on mclk_i.
`timescale 1ns/1ps
module nalu_core
    import nalu_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Instruction from the sequencer
    input wire nalu_instr_s instr_i,
    input wire logic skip_i,
    output logic busy_o,
    output logic skip_req_o,
    // Power-down return
    input wire logic wake_i,
    // Data memory at the data pointer
    input wire logic [3:0] mem_rdata_i,
    output logic [3:0] mem_wdata_o,
    output logic mem_we_o,
    // Pointer register low bits
    input wire logic [2:0] pointer_low_bits_i,
    // Program memory table port
    output logic rom_req_o,
    output logic [13:0] rom_addr_o,
    input wire logic rom_valid_i,
    input wire logic [7:0] rom_data_i,
    // Return stack
    output logic stack_push_o,
    output logic stack_pop_o,
    // Visible state
    output logic [3:0] acc_o,
    output logic [3:0] aux_o,
    output logic carry_flag_o,
    output logic bank_o
);

    nalu_state_s st_r;
    nalu_state_s st_nxt;
    nalu_res_s alu_res;
    logic take;
    logic exec;
    logic tab_done;

    // A skipped slot is still taken so that the sequencer can move on, but it
    // executes nothing.
    assign take = instr_i.valid && (st_r.tab == NALU_TAB_IDLE);
    assign exec = take && !skip_i;
    assign tab_done = (st_r.tab == NALU_TAB_WAIT) && rom_valid_i;

    nalu_alu u_alu (
        .op_i(instr_i.op),
        .imm_i(instr_i.imm),
        .acc_i(st_r.acc),
        .carry_i(st_r.carry),
        .mem_i(mem_rdata_i),
        .res_o(alu_res)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.skip_req = 1'b0;
        st_nxt.mem_we = 1'b0;
        st_nxt.push = 1'b0;
        st_nxt.pop = 1'b0;
        if (take)
        begin
            // Any coded load, executed or not, continues the run.
            st_nxt.load_run = (instr_i.op == NALU_OP_LOAD_IMM);
        end
        if (exec)
        begin
            case (instr_i.op)
                NALU_OP_LOAD_IMM:
                begin
                    if (!st_r.load_run)
                    begin
                        st_nxt.acc = instr_i.imm;
                    end
                end
                NALU_OP_TABLE_READ:
                begin
                    st_nxt.rom_req = 1'b1;
                    st_nxt.rom_addr = {st_r.bank, instr_i.page,
                                       pointer_low_bits_i, st_r.acc};
                    st_nxt.push = 1'b1;
                    st_nxt.tab = NALU_TAB_WAIT;
                end
                NALU_OP_BANK_SET:
                begin
                    st_nxt.bank = 1'b1;
                end
                NALU_OP_BANK_CLR:
                begin
                    st_nxt.bank = NALU_BANK_LOW;
                end
                default:
                begin
                    if (alu_res.acc_we)
                    begin
                        st_nxt.acc = alu_res.acc;
                    end
                    if (alu_res.carry_we)
                    begin
                        st_nxt.carry = alu_res.carry;
                    end
                    st_nxt.mem_we = alu_res.mem_we;
                    st_nxt.mem_wdata = alu_res.mem;
                    st_nxt.skip_req = alu_res.skip;
                end
            endcase
        end
        if (tab_done)
        begin
            st_nxt.aux = rom_data_i[NALU_ROM_DW-1:NALU_HI_LSB];
            st_nxt.acc = rom_data_i[NALU_HI_LSB-1:0];
            st_nxt.rom_req = 1'b0;
            st_nxt.pop = 1'b1;
            st_nxt.tab = NALU_TAB_IDLE;
        end
        if (wake_i)
        begin
            st_nxt.bank = NALU_BANK_LOW;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= NALU_STATE_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign busy_o = (st_r.tab != NALU_TAB_IDLE);
    assign skip_req_o = st_r.skip_req;
    assign mem_wdata_o = st_r.mem_wdata;
    assign mem_we_o = st_r.mem_we;
    assign rom_req_o = st_r.rom_req;
    assign rom_addr_o = st_r.rom_addr;
    assign stack_push_o = st_r.push;
    assign stack_pop_o = st_r.pop;
    assign acc_o = st_r.acc;
    assign aux_o = st_r.aux;
    assign carry_flag_o = st_r.carry;
    assign bank_o = st_r.bank;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // One strobe per executed operation for the checks below. A function that read
    // exec itself would see the values after the edge, not the sampled ones.
    logic [19:0] exec_hit;
    assign exec_hit = exec ? (20'h00001 << instr_i.op) : 20'h00000;

    load_first_a: assert property (
        exec_hit[NALU_OP_LOAD_IMM] && !st_r.load_run |=> acc_o == $past(instr_i.imm))
        else $error("First load of a run did not reach the accumulator");

    load_run_a: assert property (
        exec_hit[NALU_OP_LOAD_IMM] && st_r.load_run && !wake_i |=> $stable(acc_o))
        else $error("Load inside a run changed the accumulator");

    load_track_a: assert property (
        take |=> st_r.load_run == $past(instr_i.op == NALU_OP_LOAD_IMM))
        else $error("Load run not tracked across taken slots");

    table_split_a: assert property (
        tab_done |=> aux_o == $past(rom_data_i[7:4]) && acc_o == $past(rom_data_i[3:0]))
        else $error("Table word not split into auxiliary and accumulator");

    rom_busy_a: assert property (
        rom_req_o == busy_o)
        else $error("Table request and busy disagree");

    table_addr_a: assert property (
        exec_hit[NALU_OP_TABLE_READ] |=> rom_req_o && rom_addr_o[6:0]
            == {$past(pointer_low_bits_i), $past(acc_o)})
        else $error("Table address not built from pointer and accumulator");

    // While program memory is slow the sequencer keeps the read on the port, so
    // nothing else may slip in and the address must not move under the memory.
    table_wait_a: assert property (
        busy_o && !rom_valid_i |=> busy_o && $stable(rom_addr_o) && $stable(acc_o)
            && !skip_req_o && !mem_we_o)
        else $error("Waiting table read lost its address or took an instruction");

    stack_level_a: assert property (
        exec_hit[NALU_OP_TABLE_READ] |=> stack_push_o && busy_o && !stack_pop_o)
        else $error("Table read did not hold a stack level");

    stack_hold_a: assert property (
        busy_o |-> !stack_pop_o)
        else $error("Stack level released while the table read waits");

    stack_release_a: assert property (
        tab_done |=> stack_pop_o && !busy_o && !rom_req_o)
        else $error("Table read did not release its stack level");

    pop_pulse_a: assert property (
        stack_pop_o |=> !stack_pop_o)
        else $error("Stack release lasted more than one cycle");

    bank_page_a: assert property (
        exec_hit[NALU_OP_TABLE_READ] |=> rom_addr_o[13] == $past(bank_o))
        else $error("Table page ignores the bank selection");

    bank_op_a: assert property (
        (exec_hit[NALU_OP_BANK_SET] || exec_hit[NALU_OP_BANK_CLR]) && !wake_i
            |=> bank_o == $past(instr_i.op == NALU_OP_BANK_SET))
        else $error("Bank instruction did not select its pages");

    bank_wake_a: assert property (
        wake_i |=> !bank_o)
        else $error("Wake did not return to the low pages");

    add_plain_a: assert property (
        exec_hit[NALU_OP_ADD_MEM] |=> $stable(carry_flag_o)
            && acc_o == 4'($past(acc_o) + $past(mem_rdata_i)))
        else $error("Plain add gave a wrong sum or touched carry");

    add_carry_a: assert property (
        exec_hit[NALU_OP_ADDC_MEM] |=> {carry_flag_o, acc_o} == 5'({1'b0, $past(acc_o)}
            + {1'b0, $past(mem_rdata_i)} + {4'h0, $past(carry_flag_o)}))
        else $error("Add with carry gave a wrong result");

    add_imm_skip_a: assert property (
        exec_hit[NALU_OP_ADD_IMM] |=> $stable(carry_flag_o) && skip_req_o
            == !(5'({1'b0, $past(acc_o)} + {1'b0, $past(instr_i.imm)}) > 5'h0f))
        else $error("Immediate add skip or carry wrong");

    and_a: assert property (
        exec_hit[NALU_OP_AND_MEM] |=> acc_o == ($past(acc_o) & $past(mem_rdata_i)))
        else $error("AND with memory gave a wrong result");

    or_a: assert property (
        exec_hit[NALU_OP_OR_MEM] |=> acc_o == ($past(acc_o) | $past(mem_rdata_i)))
        else $error("OR with memory gave a wrong result");

    carry_set_a: assert property (
        exec_hit[NALU_OP_SET_CARRY] |=> carry_flag_o)
        else $error("Set carry left the flag low");

    carry_clear_a: assert property (
        exec_hit[NALU_OP_CLR_CARRY] |=> !carry_flag_o)
        else $error("Clear carry left the flag high");

    carry_skip_a: assert property (
        exec_hit[NALU_OP_TEST_CARRY] |=> skip_req_o == !$past(carry_flag_o))
        else $error("Carry test skip wrong");

    compl_a: assert property (
        exec_hit[NALU_OP_COMPL] |=> acc_o == ~$past(acc_o))
        else $error("Complement gave a wrong result");

    rotate_a: assert property (
        exec_hit[NALU_OP_ROT_RIGHT] |=> carry_flag_o == $past(acc_o[0])
            && acc_o == {$past(carry_flag_o), $past(acc_o[3:1])})
        else $error("Rotate through carry wrong");

    bit_write_a: assert property (
        exec_hit[NALU_OP_BIT_SET] || exec_hit[NALU_OP_BIT_CLR] |=> mem_we_o
            && mem_wdata_o[$past(instr_i.imm[1:0])] == $past(instr_i.op == NALU_OP_BIT_SET))
        else $error("Bit write did not reach the selected bit");

    bit_skip_a: assert property (
        exec_hit[NALU_OP_BIT_TEST] |=> skip_req_o == !$past(mem_rdata_i[instr_i.imm[1:0]]))
        else $error("Bit test skip wrong");

    cmp_skip_a: assert property (
        exec_hit[NALU_OP_CMP_MEM] |=> skip_req_o == ($past(acc_o) == $past(mem_rdata_i)))
        else $error("Memory compare skip wrong");

    cmp_imm_a: assert property (
        exec_hit[NALU_OP_CMP_IMM] |=> skip_req_o == ($past(acc_o) == $past(instr_i.imm)))
        else $error("Immediate compare skip wrong");

    mem_quiet_a: assert property (
        !exec_hit[NALU_OP_BIT_SET] && !exec_hit[NALU_OP_BIT_CLR] |=> !mem_we_o)
        else $error("Memory written by an instruction that owns no write");

    // A skipped slot still counts in a load run, so only visible state is judged here.
    skipped_quiet_a: assert property (
        take && skip_i && !tab_done && !wake_i |=> $stable(acc_o) && $stable(carry_flag_o)
            && $stable(bank_o) && !mem_we_o && !skip_req_o && !stack_push_o)
        else $error("Skipped instruction changed state");

    // The covers mark the scenarios that the bench is expected to reach.
    load_run_c: cover property (
        exec_hit[NALU_OP_LOAD_IMM] ##1 exec_hit[NALU_OP_LOAD_IMM]);
    table_read_c: cover property (
        exec_hit[NALU_OP_TABLE_READ] && bank_o ##[1:20] tab_done);
    add_skip_c: cover property (
        exec_hit[NALU_OP_ADD_IMM] ##1 skip_req_o);
    bit_test_c: cover property (
        exec_hit[NALU_OP_BIT_TEST] ##1 skip_req_o);
    wake_bank_c: cover property (
        exec_hit[NALU_OP_BANK_SET] && wake_i);

endmodule

/* File: bench/tb_nibble_alu_skip_logic.sv */
// Self-checking testbench of the nibble ALU core: random and corner instruction streams.
// Assumes the core on mclk_i alone; the bench plays sequencer, data memory and program memory.
`timescale 1ns/1ps
module tb_nibble_alu_skip_logic;
import nalu_pkg::*;

logic mclk_i = 1'b0;
logic rst_n_i = 1'b0;
logic skip_i = 1'b0;
logic wake_i = 1'b0;
logic rom_valid_i = 1'b0;
nalu_instr_s instr_i = '0;
logic [3:0] mem_rdata_i = 4'h0;
logic [2:0] pointer_low_bits_i = 3'h0;
logic [7:0] rom_data_i = 8'h00;
logic busy_o, skip_req_o, mem_we_o, rom_req_o, stack_push_o, stack_pop_o, carry_flag_o, bank_o;
logic [3:0] mem_wdata_o, acc_o, aux_o;
logic [13:0] rom_addr_o;
int fail_count = 0;
int comparisons = 0;
int cycles = 0;
logic [3:0] e_acc, e_aux, e_wd;
logic e_carry, e_bank, e_run, e_skip, e_we, e_pop;

nalu_core dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .skip_i(skip_i), .busy_o(busy_o),
    .skip_req_o(skip_req_o), .wake_i(wake_i), .mem_rdata_i(mem_rdata_i),
    .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .pointer_low_bits_i(pointer_low_bits_i),
    .rom_req_o(rom_req_o), .rom_addr_o(rom_addr_o), .rom_valid_i(rom_valid_i),
    .rom_data_i(rom_data_i), .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
    .acc_o(acc_o), .aux_o(aux_o), .carry_flag_o(carry_flag_o), .bank_o(bank_o)
);

initial
begin
    forever #12.5 mclk_i = ~mclk_i;
end

task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask

// The ceiling leaves ample margin over roughly 1700 cycles of planned traffic.
always @(posedge mclk_i)
begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
        fail_count++;
        report_and_stop();
    end
end

task automatic cmp(input string nm, input logic [13:0] exp, input logic [13:0] got);
    comparisons++;
    if (got !== exp)
    begin
        fail_count++;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
endtask

// Callers clear skchk only where skip_req_o would carry no defined answer.
task automatic check_state(input logic skchk);
    cmp("acc", 14'(e_acc), 14'(acc_o));
    cmp("aux", 14'(e_aux), 14'(aux_o));
    cmp("carry", 14'(e_carry), 14'(carry_flag_o));
    cmp("bank", 14'(e_bank), 14'(bank_o));
    cmp("mem_we", 14'(e_we), 14'(mem_we_o));
    if (e_we)
        cmp("mem_wdata", 14'(e_wd), 14'(mem_wdata_o));
    if (skchk)
        cmp("skip_req", 14'(e_skip), 14'(skip_req_o));
    cmp("busy", 14'h0, 14'(busy_o));
    cmp("push", 14'h0, 14'(stack_push_o));
    cmp("pop", 14'(e_pop), 14'(stack_pop_o));
endtask

task automatic issue(input nalu_op_e op, input logic [3:0] imm, input logic [3:0] mem,
                     input logic skp, input logic wk);
    logic [4:0] s;
    instr_i = '{valid: 1'b1, op: op, imm: imm, page: 6'($urandom)};
    mem_rdata_i = mem;
    skip_i = skp;
    wake_i = wk;
    rom_valid_i = 1'($urandom);
    rom_data_i = 8'($urandom);
    pointer_low_bits_i = 3'($urandom);
    e_skip = 1'b0;
    e_we = 1'b0;
    e_pop = 1'b0;
    s = 5'(e_acc) + 5'(imm);
    if (!skp)
    begin
        case (op)
            NALU_OP_LOAD_IMM: if (!e_run) e_acc = imm;
            NALU_OP_BANK_SET: e_bank = 1'b1;
            NALU_OP_BANK_CLR: e_bank = 1'b0;
            NALU_OP_ADD_MEM: e_acc = e_acc + mem;
            NALU_OP_ADDC_MEM: {e_carry, e_acc} = 5'(e_acc) + 5'(mem) + 5'(e_carry);
            NALU_OP_ADD_IMM:
            begin
                e_acc = s[3:0];
                e_skip = ~s[4];
            end
            NALU_OP_AND_MEM: e_acc = e_acc & mem;
            NALU_OP_OR_MEM: e_acc = e_acc | mem;
            NALU_OP_SET_CARRY: e_carry = 1'b1;
            NALU_OP_CLR_CARRY: e_carry = 1'b0;
            NALU_OP_TEST_CARRY: e_skip = ~e_carry;
            NALU_OP_COMPL: e_acc = ~e_acc;
            NALU_OP_ROT_RIGHT: {e_acc, e_carry} = {e_carry, e_acc};
            NALU_OP_BIT_SET:
            begin
                e_we = 1'b1;
                e_wd = mem | (4'h1 << imm[1:0]);
            end
            NALU_OP_BIT_CLR:
            begin
                e_we = 1'b1;
                e_wd = mem & ~(4'h1 << imm[1:0]);
            end
            NALU_OP_BIT_TEST: e_skip = ~mem[imm[1:0]];
            NALU_OP_CMP_MEM: e_skip = (e_acc == mem);
            NALU_OP_CMP_IMM: e_skip = (e_acc == imm);
            default: ;
        endcase
    end
    // A skipped load still extends a run; wake always lands on the low bank.
    e_run = (op == NALU_OP_LOAD_IMM);
    if (wk)
        e_bank = 1'b0;
    @(negedge mclk_i);
    check_state(1'b1);
endtask

task automatic table_read(input logic skp, input int dly);
    logic [5:0] pg;
    logic [2:0] pt;
    logic [7:0] d;
    logic [13:0] a;
    pg = 6'($urandom);
    pt = 3'($urandom);
    d = 8'($urandom);
    a = {e_bank, pg, pt, e_acc};
    instr_i = '{valid: 1'b1, op: NALU_OP_TABLE_READ, imm: 4'($urandom), page: pg};
    pointer_low_bits_i = pt;
    skip_i = skp;
    wake_i = 1'b0;
    rom_valid_i = 1'b0;
    e_run = 1'b0;
    e_skip = 1'b0;
    e_we = 1'b0;
    e_pop = 1'b0;
    @(negedge mclk_i);
    if (skp)
        check_state(1'b1);
    else
    begin
        cmp("rom_req", 14'h1, 14'(rom_req_o));
        cmp("push", 14'h1, 14'(stack_push_o));
        cmp("rom_addr", a, rom_addr_o);
        // The sequencer keeps presenting the read while the core is busy.
        repeat (dly)
        begin
            @(negedge mclk_i);
            cmp("busy", 14'h1, 14'(busy_o));
            cmp("rom_addr", a, rom_addr_o);
        end
        rom_valid_i = 1'b1;
        rom_data_i = d;
        e_acc = d[3:0];
        e_aux = d[7:4];
        e_pop = 1'b1;
        @(negedge mclk_i);
        check_state(1'b1);
        cmp("rom_req", 14'h0, 14'(rom_req_o));
    end
endtask

task automatic do_reset();
    instr_i.valid = 1'b0;
    rst_n_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    @(negedge mclk_i);
    {e_acc, e_aux, e_carry, e_bank, e_run, e_skip, e_we, e_pop} = '0;
    check_state(1'b1);
endtask

initial
begin
    int r;
    void'($urandom(32'h7267c3f4));
    do_reset();
    issue(NALU_OP_LOAD_IMM, 4'h3, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_LOAD_IMM, 4'h5, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_LOAD_IMM, 4'h7, 4'h0, 1'b1, 1'b0);
    issue(NALU_OP_LOAD_IMM, 4'h9, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_COMPL, 4'h0, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_LOAD_IMM, 4'hf, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_ADD_IMM, 4'h1, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_ADD_IMM, 4'h2, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_SET_CARRY, 4'h0, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_ADDC_MEM, 4'h0, 4'hf, 1'b0, 1'b0);
    issue(NALU_OP_ROT_RIGHT, 4'h0, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_TEST_CARRY, 4'h0, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_CMP_IMM, e_acc, 4'h0, 1'b0, 1'b0);
    issue(NALU_OP_CMP_MEM, 4'h0, e_acc, 1'b0, 1'b0);
    for (int j = 0; j < 4; j++)
    begin
        issue(NALU_OP_BIT_SET, 4'(j), 4'h0, 1'b0, 1'b0);
        issue(NALU_OP_BIT_CLR, 4'(j), 4'hf, 1'b0, 1'b0);
        issue(NALU_OP_BIT_TEST, 4'(j), 4'h1 << j, 1'b0, 1'b0);
        issue(NALU_OP_BIT_TEST, 4'(j), ~(4'h1 << j), 1'b0, 1'b0);
    end
    issue(NALU_OP_BANK_SET, 4'h0, 4'h0, 1'b0, 1'b0);
    table_read(1'b0, 0);
    table_read(1'b0, 3);
    table_read(1'b1, 0);
    issue(NALU_OP_BANK_SET, 4'h0, 4'h0, 1'b0, 1'b1);
    issue(NALU_OP_BANK_SET, 4'h0, 4'h0, 1'b0, 1'b0);
    do_reset();
    for (int i = 0; i < 1500; i++)
    begin
        r = int'($urandom % 20);
        if (r == 2)
            table_read(1'($urandom % 4 == 0), int'($urandom % 4));
        else
            issue(nalu_op_e'(5'(r)), 4'($urandom), 4'($urandom), 1'($urandom % 5 == 0),
                  1'($urandom % 10 == 0));
    end
    report_and_stop();
end

endmodule
